/* include/hpr_pkg.sv */
// constants, register map and types of the haptic power and reset controller
package hpr_pkg;

	// clock and documented times
	localparam int CLK_MHZ         = 100;
	localparam int TIMEOUT_STEP_MS = 512;
	localparam int WAKE_MIN_US     = 300;
	localparam int WAKE_MAX_US     = 400;
	localparam int TRIG_HOLD_US    = 100;

	// derived cycle counts
	localparam int STEP_CYCLES      = TIMEOUT_STEP_MS * 1000 * CLK_MHZ;
	localparam int WAKE_CYCLES      = WAKE_MIN_US * CLK_MHZ;
	localparam int TRIG_HOLD_CYCLES = TRIG_HOLD_US * CLK_MHZ;

	// register byte offsets
	localparam logic [7:0] OFS_STATUS   = 8'h00;
	localparam logic [7:0] OFS_CONTROL  = 8'h04;
	localparam logic [7:0] OFS_SETTINGS = 8'h08;
	localparam logic [7:0] OFS_HBRIDGE  = 8'h0c;
	localparam logic [7:0] OFS_OTEMP    = 8'h10;

	// status fields
	localparam int ST_RESET_BIT  = 0;
	localparam int ST_FAST_BIT   = 1;
	localparam int ST_ACTIVE_BIT = 2;
	localparam int ST_OC_BIT     = 3;
	localparam int ST_OT_BIT     = 4;

	// control fields
	localparam int CT_TRIG_BIT     = 0;
	localparam int CT_SOFT_RST_BIT = 1;
	localparam int CT_ACK_BIT      = 2;

	// settings fields
	localparam int SET_MODE_LSB = 0;
	localparam int SET_TOUT_LSB = 8;

	// bridge setup fields
	localparam int HB_STRENGTH_LSB = 0;
	localparam int HB_OCP_BIT      = 4;
	localparam int HB_OTP_BIT      = 5;
	localparam int HB_STP_BIT      = 6;
	localparam int HB_GND_IDLE_BIT = 7;
	localparam int HB_EXT_BIT      = 8;

	// over-temperature fields
	localparam int OT_THRESH_LSB = 0;
	localparam int OT_HYST_BIT   = 8;

	localparam int         STRENGTH_W  = 3;
	localparam int         STAGES      = 7;
	localparam logic [2:0] OCP_OFF_A   = 3'h1;
	localparam logic [2:0] OCP_OFF_B   = 3'h3;
	localparam logic [7:0] OT_HYST_DROP = 8'h04;

	typedef enum logic [1:0] {
		MODE_FAST  = 2'h0,
		MODE_SLEEP = 2'h1,
		MODE_AUTO  = 2'h2
	} pwr_mode_e;

	typedef enum logic [2:0] {
		PS_FAST  = 3'h1,
		PS_SLEEP = 3'h2,
		PS_WAKE  = 3'h4
	} pwr_state_e;

	typedef struct packed {
		logic [1:0] mode;
		logic [7:0] timeout;
		logic [2:0] strength;
		logic       ocp_en;
		logic       otp_en;
		logic       stp_en;
		logic       gnd_idle;
		logic       ext;
		logic [7:0] ot_thresh;
		logic       hyst_en;
	} cfg_s;

	localparam cfg_s CFG_DEFAULT = '{
		mode:      2'h2,
		timeout:   8'h01,
		strength:  3'h5,
		ocp_en:    1'b0,
		otp_en:    1'b1,
		stp_en:    1'b1,
		gnd_idle:  1'b0,
		ext:       1'b0,
		ot_thresh: 8'h80,
		hyst_en:   1'b1
	};

	// pin order in the synchroniser
	localparam int PIN_HARD = 0;
	localparam int PIN_TRIG = 1;
	localparam int PIN_SCLK = 2;
	localparam int PIN_OC   = 3;
	localparam int PIN_W    = 4;
	localparam logic [3:0] PIN_RST_VAL = 4'h1;

endpackage : hpr_pkg

/* design/pin_sync.sv */
// two-flop synchroniser for the asynchronous input pins
`timescale 1ns/10ps
module pin_sync #(
	parameter int             W       = 4,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} sync_s;

	sync_s s_r;
	sync_s s_nxt;

	always_comb
	begin
		s_nxt.meta = d;
		s_nxt.sync = s_r.meta;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_r <= {RST_VAL, RST_VAL};
		end
		else if (ce)
		begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.sync;

endmodule : pin_sync

/* design/haptic_power_reset_bridge_ctrl.sv */
// power state, reset handshake, bridge setup and protections behind an APB slave
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/10ps
module haptic_power_reset_bridge_ctrl #(
	parameter int STEP_CYCLES      = hpr_pkg::STEP_CYCLES,
	parameter int WAKE_CYCLES      = hpr_pkg::WAKE_CYCLES,
	parameter int TRIG_HOLD_CYCLES = hpr_pkg::TRIG_HOLD_CYCLES,
	parameter int STAGES           = hpr_pkg::STAGES
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              hard_reset_n,
	input  wire logic              trig_pin,
	input  wire logic              serial_clk,
	input  wire logic              oc_sense,
	input  wire logic [7:0]        temp_code,
	input  wire logic              wave_running,
	input  wire logic              drive_on,
	input  wire logic              drive_p,
	input  wire logic              drive_n,
	output logic                   haptic_start,
	output logic                   power_fast,
	output logic                   core_power_en,
	output logic                   motor_p_o,
	output logic                   motor_p_oe,
	output logic                   motor_n_o,
	output logic                   motor_n_oe,
	output logic      [STAGES-1:0] stage_en
);

	localparam int STEP_W = $clog2(STEP_CYCLES + 1);
	localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);
	localparam int HOLD_W = $clog2(TRIG_HOLD_CYCLES + 1);
	localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYCLES - 1);
	localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_CYCLES - 1);
	localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(TRIG_HOLD_CYCLES - 1);

	typedef struct packed {
		hpr_pkg::cfg_s       cfg;
		logic                rst_flag;
		logic                ack;
		logic                soft_req;
		logic                pending;
		logic                oc_flag;
		logic                ot_flag;
		logic                ot_hot;
		logic                hold_done;
		logic [HOLD_W-1:0]   hold_cnt;
		logic [STEP_W-1:0]   step_cnt;
		logic [8:0]          tout_cnt;
		logic [WAKE_W-1:0]   wake_cnt;
		hpr_pkg::pwr_state_e state;
		logic                sclk_prev;
		logic [1:0]          dir_prev;
		logic [31:0]         prdata;
		logic                pready;
		logic                pslverr;
		logic                start;
		logic                fast;
		logic                core_en;
		logic                mp_o;
		logic                mp_oe;
		logic                mn_o;
		logic                mn_oe;
		logic [STAGES-1:0]   stage;
	} st_s;

	st_s s_r;
	st_s s_nxt;

	logic [hpr_pkg::PIN_W-1:0] pins;
	logic                      pin_hard;
	logic                      pin_trig;
	logic                      pin_sclk;
	logic                      pin_oc;
	logic                      setup;
	logic                      xfer_done;
	logic                      wr_done;
	logic                      map_hit;
	logic                      status_rd;
	logic                      ctrl_wr;
	logic                      addressed;
	logic                      auto_mode;
	logic                      hold_fire;
	logic                      trig_cmd;
	logic                      trig_accept;
	logic                      dev_rst;
	logic                      stay_awake;
	logic                      timed_out;
	logic                      ocp_allowed;
	logic                      oc_now;
	logic                      ot_hot_nxt;
	logic                      ot_trip;
	logic                      trip;
	logic                      awake;
	logic                      dead;
	logic                      drive_ok;
	logic [7:0]                ot_low;
	logic [31:0]               rd_word;
	logic [STAGES-1:0]         stage_mask;

	pin_sync #(
		.W       (hpr_pkg::PIN_W),
		.RST_VAL (hpr_pkg::PIN_RST_VAL)
	) u_pin_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.d       ({oc_sense, serial_clk, trig_pin, hard_reset_n}),
		.q       (pins)
	);

	assign pin_hard = pins[hpr_pkg::PIN_HARD];
	assign pin_trig = pins[hpr_pkg::PIN_TRIG];
	assign pin_sclk = pins[hpr_pkg::PIN_SCLK];
	assign pin_oc   = pins[hpr_pkg::PIN_OC];

	// thermometer of active bridge stages
	genvar gi;
	generate
		for (gi = 0; gi < STAGES; gi++)
		begin : g_stage
			assign stage_mask[gi] = (32'(s_r.cfg.strength) > gi);
		end
	endgenerate

	assign setup     = psel & ~penable;
	assign xfer_done = psel & penable & s_r.pready;
	assign wr_done   = xfer_done & pwrite & ~s_r.pslverr;
	assign map_hit   = (paddr == hpr_pkg::OFS_STATUS) | (paddr == hpr_pkg::OFS_CONTROL) |
		(paddr == hpr_pkg::OFS_SETTINGS) | (paddr == hpr_pkg::OFS_HBRIDGE) |
		(paddr == hpr_pkg::OFS_OTEMP);
	// fault flags clear at the edge where the read data is captured
	assign status_rd = setup & ~s_r.pready & ~pwrite & (paddr == hpr_pkg::OFS_STATUS);
	assign ctrl_wr   = wr_done & (paddr == hpr_pkg::OFS_CONTROL);
	assign addressed = (pin_sclk & ~s_r.sclk_prev) | xfer_done;
	assign auto_mode = (s_r.cfg.mode != hpr_pkg::MODE_FAST) &&
		(s_r.cfg.mode != hpr_pkg::MODE_SLEEP);

	assign hold_fire   = pin_trig & ~s_r.hold_done & (s_r.hold_cnt == HOLD_LAST);
	assign trig_cmd    = (ctrl_wr & pwdata[hpr_pkg::CT_TRIG_BIT]) | hold_fire;
	assign trig_accept = trig_cmd & ~s_r.rst_flag & ~wave_running & ~s_r.pending;
	assign dev_rst     = ~pin_hard | (s_r.soft_req & ~wave_running);
	assign stay_awake  = pin_trig | wave_running | s_r.pending | s_r.start;
	assign timed_out   = s_r.tout_cnt >= {1'b0, s_r.cfg.timeout};

	assign ocp_allowed = (s_r.cfg.strength != hpr_pkg::OCP_OFF_A) &&
		(s_r.cfg.strength != hpr_pkg::OCP_OFF_B);
	assign oc_now      = s_r.cfg.ocp_en & ocp_allowed & pin_oc;
	assign ot_low      = (s_r.cfg.ot_thresh > hpr_pkg::OT_HYST_DROP) ?
		(s_r.cfg.ot_thresh - hpr_pkg::OT_HYST_DROP) : 8'h00;
	// once hot, release only at or below the lowered threshold
	assign ot_hot_nxt  = (s_r.ot_hot & s_r.cfg.hyst_en) ? (temp_code > ot_low) :
		(temp_code > s_r.cfg.ot_thresh);
	assign ot_trip     = s_r.cfg.otp_en & s_r.ot_hot;
	assign trip        = oc_now | ot_trip;
	assign awake       = (s_r.state == hpr_pkg::PS_FAST);
	// one low cycle on a direction change keeps both sides from conducting
	assign dead        = s_r.cfg.stp_en & ((drive_p & drive_n) |
		({drive_p, drive_n} != s_r.dir_prev));
	assign drive_ok    = drive_on & awake & ~trip & (s_r.cfg.strength != 3'h0);

	always_comb
	begin
		rd_word = 32'h0000_0000;
		unique case (paddr)
			hpr_pkg::OFS_STATUS:
			begin
				rd_word[hpr_pkg::ST_RESET_BIT]  = s_r.rst_flag;
				rd_word[hpr_pkg::ST_FAST_BIT]   = awake;
				rd_word[hpr_pkg::ST_ACTIVE_BIT] = wave_running;
				rd_word[hpr_pkg::ST_OC_BIT]     = s_r.oc_flag;
				rd_word[hpr_pkg::ST_OT_BIT]     = s_r.ot_flag;
			end
			hpr_pkg::OFS_CONTROL:
			begin
				rd_word[hpr_pkg::CT_TRIG_BIT]     = s_r.pending;
				rd_word[hpr_pkg::CT_SOFT_RST_BIT] = s_r.soft_req;
				rd_word[hpr_pkg::CT_ACK_BIT]      = s_r.ack;
			end
			hpr_pkg::OFS_SETTINGS:
			begin
				rd_word[hpr_pkg::SET_MODE_LSB +: 2] = s_r.cfg.mode;
				rd_word[hpr_pkg::SET_TOUT_LSB +: 8] = s_r.cfg.timeout;
			end
			hpr_pkg::OFS_HBRIDGE:
			begin
				rd_word[hpr_pkg::HB_STRENGTH_LSB +: hpr_pkg::STRENGTH_W] = s_r.cfg.strength;
				rd_word[hpr_pkg::HB_OCP_BIT]      = s_r.cfg.ocp_en;
				rd_word[hpr_pkg::HB_OTP_BIT]      = s_r.cfg.otp_en;
				rd_word[hpr_pkg::HB_STP_BIT]      = s_r.cfg.stp_en;
				rd_word[hpr_pkg::HB_GND_IDLE_BIT] = s_r.cfg.gnd_idle;
				rd_word[hpr_pkg::HB_EXT_BIT]      = s_r.cfg.ext;
			end
			hpr_pkg::OFS_OTEMP:
			begin
				rd_word[hpr_pkg::OT_THRESH_LSB +: 8] = s_r.cfg.ot_thresh;
				rd_word[hpr_pkg::OT_HYST_BIT]        = s_r.cfg.hyst_en;
			end
			default:
			begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	always_comb
	begin
		s_nxt         = s_r;
		s_nxt.start   = 1'b0;
		s_nxt.pready  = 1'b0;
		s_nxt.pslverr = 1'b0;

		// bus answer one cycle after the setup edge
		if (setup & ~s_r.pready)
		begin
			s_nxt.pready  = 1'b1;
			s_nxt.pslverr = ~map_hit;
			s_nxt.prdata  = pwrite ? 32'h0000_0000 : rd_word;
		end

		// device clears the acknowledge one cycle after it is written
		if (s_r.ack)
		begin
			s_nxt.ack = 1'b0;
			if (s_r.rst_flag)
			begin
				s_nxt.rst_flag = 1'b0;
			end
		end
		if (s_r.soft_req)
		begin
			s_nxt.soft_req = 1'b0;
		end

		if (wr_done)
		begin
			unique case (paddr)
				hpr_pkg::OFS_CONTROL:
				begin
					if (pwdata[hpr_pkg::CT_ACK_BIT])
					begin
						s_nxt.ack = 1'b1;
					end
					if (pwdata[hpr_pkg::CT_SOFT_RST_BIT])
					begin
						s_nxt.soft_req = 1'b1;
					end
				end
				hpr_pkg::OFS_SETTINGS:
				begin
					s_nxt.cfg.mode    = pwdata[hpr_pkg::SET_MODE_LSB +: 2];
					s_nxt.cfg.timeout = pwdata[hpr_pkg::SET_TOUT_LSB +: 8];
				end
				hpr_pkg::OFS_HBRIDGE:
				begin
					s_nxt.cfg.strength = pwdata[hpr_pkg::HB_STRENGTH_LSB +: hpr_pkg::STRENGTH_W];
					s_nxt.cfg.ocp_en   = pwdata[hpr_pkg::HB_OCP_BIT];
					s_nxt.cfg.otp_en   = pwdata[hpr_pkg::HB_OTP_BIT];
					s_nxt.cfg.stp_en   = pwdata[hpr_pkg::HB_STP_BIT];
					s_nxt.cfg.gnd_idle = pwdata[hpr_pkg::HB_GND_IDLE_BIT];
					s_nxt.cfg.ext      = pwdata[hpr_pkg::HB_EXT_BIT];
				end
				hpr_pkg::OFS_OTEMP:
				begin
					s_nxt.cfg.ot_thresh = pwdata[hpr_pkg::OT_THRESH_LSB +: 8];
					s_nxt.cfg.hyst_en   = pwdata[hpr_pkg::OT_HYST_BIT];
				end
				default:
				begin
					// status and unmapped words keep their contents
					s_nxt.cfg = s_r.cfg;
				end
			endcase
		end

		// sticky fault flags; a trip in the clearing cycle wins
		if (status_rd)
		begin
			s_nxt.oc_flag = 1'b0;
			s_nxt.ot_flag = 1'b0;
		end
		if (oc_now)
		begin
			s_nxt.oc_flag = 1'b1;
		end
		if (ot_trip)
		begin
			s_nxt.ot_flag = 1'b1;
		end
		s_nxt.ot_hot = ot_hot_nxt;

		// pin must stay high for the hold time to issue one command
		if (!pin_trig)
		begin
			s_nxt.hold_cnt  = '0;
			s_nxt.hold_done = 1'b0;
		end
		else if (!s_r.hold_done)
		begin
			if (s_r.hold_cnt == HOLD_LAST)
			begin
				s_nxt.hold_done = 1'b1;
			end
			else
			begin
				s_nxt.hold_cnt = s_r.hold_cnt + 1'b1;
			end
		end

		s_nxt.sclk_prev = pin_sclk;
		s_nxt.dir_prev  = {drive_p, drive_n};

		// power timeout in steps of STEP_CYCLES
		if (stay_awake | addressed | trig_cmd | ~awake)
		begin
			s_nxt.step_cnt = '0;
			s_nxt.tout_cnt = 9'h000;
		end
		else if (s_r.step_cnt == STEP_LAST)
		begin
			s_nxt.step_cnt = '0;
			if (s_r.tout_cnt != 9'h1ff)
			begin
				s_nxt.tout_cnt = s_r.tout_cnt + 9'h001;
			end
		end
		else
		begin
			s_nxt.step_cnt = s_r.step_cnt + 1'b1;
		end

		unique case (s_r.state)
			hpr_pkg::PS_FAST:
			begin
				if (s_r.pending)
				begin
					s_nxt.start   = 1'b1;
					s_nxt.pending = 1'b0;
				end
				else if (~stay_awake & ~trig_accept &
					((s_r.cfg.mode == hpr_pkg::MODE_SLEEP) | (auto_mode & timed_out)))
				begin
					s_nxt.state = hpr_pkg::PS_SLEEP;
				end
			end
			hpr_pkg::PS_SLEEP:
			begin
				if (trig_accept | pin_trig | (s_r.cfg.mode == hpr_pkg::MODE_FAST) |
					(auto_mode & addressed))
				begin
					s_nxt.state    = hpr_pkg::PS_WAKE;
					s_nxt.wake_cnt = '0;
				end
			end
			hpr_pkg::PS_WAKE:
			begin
				if (s_r.wake_cnt == WAKE_LAST)
				begin
					s_nxt.state = hpr_pkg::PS_FAST;
				end
				else
				begin
					s_nxt.wake_cnt = s_r.wake_cnt + 1'b1;
				end
			end
			default:
			begin
				s_nxt.state = hpr_pkg::PS_FAST;
			end
		endcase

		if (trig_accept)
		begin
			s_nxt.pending = 1'b1;
		end

		// motor pins
		s_nxt.mp_o  = 1'b0;
		s_nxt.mn_o  = 1'b0;
		s_nxt.mp_oe = 1'b0;
		s_nxt.mn_oe = 1'b0;
		s_nxt.stage = '0;
		if (s_nxt.state != hpr_pkg::PS_FAST)
		begin
			s_nxt.mp_oe = 1'b0;
			s_nxt.mn_oe = 1'b0;
		end
		else if (drive_ok & ~dead)
		begin
			s_nxt.mp_oe = 1'b1;
			s_nxt.mn_oe = 1'b1;
			s_nxt.mp_o  = drive_p;
			s_nxt.mn_o  = drive_n;
			s_nxt.stage = s_r.cfg.ext ? '0 : stage_mask;
		end
		else if (drive_ok | s_r.cfg.gnd_idle | s_r.cfg.ext)
		begin
			s_nxt.mp_oe = 1'b1;
			s_nxt.mn_oe = 1'b1;
		end

		// device reset restores defaults and raises the flag
		if (dev_rst)
		begin
			s_nxt.cfg       = hpr_pkg::CFG_DEFAULT;
			s_nxt.rst_flag  = 1'b1;
			s_nxt.ack       = 1'b0;
			s_nxt.soft_req  = 1'b0;
			s_nxt.pending   = 1'b0;
			s_nxt.oc_flag   = 1'b0;
			s_nxt.ot_flag   = 1'b0;
			s_nxt.start     = 1'b0;
			s_nxt.state     = hpr_pkg::PS_FAST;
			s_nxt.step_cnt  = '0;
			s_nxt.tout_cnt  = 9'h000;
		end

		s_nxt.fast    = (s_nxt.state == hpr_pkg::PS_FAST);
		s_nxt.core_en = (s_nxt.state != hpr_pkg::PS_SLEEP);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_r          <= '0;
			s_r.cfg      <= hpr_pkg::CFG_DEFAULT;
			s_r.rst_flag <= 1'b1;
			s_r.state    <= hpr_pkg::PS_FAST;
			s_r.fast     <= 1'b1;
			s_r.core_en  <= 1'b1;
		end
		else if (ce)
		begin
			s_r <= s_nxt;
		end
	end

	assign prdata        = s_r.prdata;
	assign pready        = s_r.pready;
	assign pslverr       = s_r.pslverr;
	assign haptic_start  = s_r.start;
	assign power_fast    = s_r.fast;
	assign core_power_en = s_r.core_en;
	assign motor_p_o     = s_r.mp_o;
	assign motor_p_oe    = s_r.mp_oe;
	assign motor_n_o     = s_r.mn_o;
	assign motor_n_oe    = s_r.mn_oe;
	assign stage_en      = s_r.stage;

endmodule : haptic_power_reset_bridge_ctrl

/* verif/hpr_chk.sv */
// port assertions of the haptic power and reset controller
`timescale 1ns/10ps
module hpr_chk #(
	parameter int STAGES = 7
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic [7:0]        paddr,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              trig_pin,
	input wire logic              wave_running,
	input wire logic              haptic_start,
	input wire logic              power_fast,
	input wire logic              core_power_en,
	input wire logic              motor_p_oe,
	input wire logic              motor_n_oe,
	input wire logic [STAGES-1:0] stage_en
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_unmapped;
		!(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10});
	endsequence
	a_pready_answer: assert property (s_setup |=> pready ##1 !pready)
		else $error("pready not a single pulse after setup");
	a_slverr_map: assert property (s_setup ##0 s_unmapped |=> pslverr && pready)
		else $error("unmapped access without error");
	a_sleep_float: assert property (!core_power_en |-> !motor_p_oe && !motor_n_oe && stage_en == '0)
		else $error("motor pins driven in deep sleep");
	a_oe_pair: assert property (motor_p_oe == motor_n_oe)
		else $error("motor enables differ");
	a_fast_core: assert property (power_fast |-> core_power_en)
		else $error("fast state with core off");
	a_run_awake: assert property (core_power_en && wave_running |=> core_power_en)
		else $error("sleep while waveform runs");
	a_pin_awake: assert property (trig_pin [*4] ##0 core_power_en |=> core_power_en)
		else $error("sleep while trigger pin high");
	a_wake_delay: assert property ($rose(core_power_en) |-> (!haptic_start && !power_fast) [*8])
		else $error("wake too short");
	a_start_awake: assert property (haptic_start |-> power_fast)
		else $error("start outside fast state");
endmodule : hpr_chk
bind haptic_power_reset_bridge_ctrl hpr_chk #(.STAGES(STAGES)) u_hpr_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
	.pready(pready), .pslverr(pslverr), .trig_pin(trig_pin), .wave_running(wave_running),
	.haptic_start(haptic_start), .power_fast(power_fast), .core_power_en(core_power_en),
	.motor_p_oe(motor_p_oe), .motor_n_oe(motor_n_oe), .stage_en(stage_en));

/* verif/wave_engine_model.sv */
// waveform engine model: a short alternating drive burst after each start pulse that arrives while idle
`timescale 1ns/10ps
module wave_engine_model #(
	parameter int LEN = 24
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic haptic_start,
	output logic      wave_running,
	output logic      drive_on,
	output logic      drive_p,
	output logic      drive_n
);
	int cnt;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt <= 0;
		else if (haptic_start && cnt == 0)
			cnt <= LEN;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
	assign wave_running = cnt != 0;
	assign drive_on = cnt > 2;
	// direction flips every eight cycles
	assign drive_p = drive_on && cnt[3];
	assign drive_n = drive_on && !cnt[3];
endmodule : wave_engine_model

/* verif/tb.sv */
// self-checking bench of the haptic power and reset controller
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
	logic [7:0]  paddr, temp_code;
	logic [31:0] pwdata, prdata, rv;
	logic        hard_reset_n, trig_pin, serial_clk, oc_sense, link_on;
	logic        wave_running, drive_on, drive_p, drive_n, haptic_start;
	logic        power_fast, core_power_en, motor_p_o, motor_p_oe, motor_n_o, motor_n_oe;
	logic [6:0]  stage_en;
	int          mismatches, tests_run, n;
	haptic_power_reset_bridge_ctrl #(.STEP_CYCLES(20), .WAKE_CYCLES(10),
		.TRIG_HOLD_CYCLES(5), .STAGES(7)) u_haptic_power_reset_bridge_ctrl (
		.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hard_reset_n(hard_reset_n), .trig_pin(trig_pin),
		.serial_clk(serial_clk), .oc_sense(oc_sense), .temp_code(temp_code),
		.wave_running(wave_running), .drive_on(drive_on), .drive_p(drive_p),
		.drive_n(drive_n), .haptic_start(haptic_start), .power_fast(power_fast),
		.core_power_en(core_power_en), .motor_p_o(motor_p_o), .motor_p_oe(motor_p_oe),
		.motor_n_o(motor_n_o), .motor_n_oe(motor_n_oe), .stage_en(stage_en));
	wave_engine_model u_wave_engine_model (.pclk(pclk), .presetn(presetn),
		.haptic_start(haptic_start), .wave_running(wave_running), .drive_on(drive_on),
		.drive_p(drive_p), .drive_n(drive_n));
	initial
	begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	// serial clock only toggles while a frame is on
	initial
	begin
		#3;
		forever #80 serial_clk = link_on ? ~serial_clk : 1'b0;
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k = 0;
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
		rv = prdata;
		re = pslverr;
		if (k >= 50) mismatches++;
		psel <= 0; penable <= 0;
		@(posedge pclk);
	endtask : apb
	task automatic wait_for(ref logic s, input logic v, input int m);
		n = 0;
		while (s !== v && n < m) begin @(posedge pclk); n++; end
	endtask : wait_for
	task automatic t_defaults;
		apb(0, hpr_pkg::OFS_STATUS, 0); `CHK(rv, 32'h3)
		apb(0, hpr_pkg::OFS_SETTINGS, 0); `CHK(rv, 32'h102)
		apb(0, hpr_pkg::OFS_HBRIDGE, 0); `CHK(rv, 32'h65)
		apb(0, hpr_pkg::OFS_OTEMP, 0); `CHK(rv, 32'h180)
		apb(0, 8'h14, 0); `CHK({re, rv}, 33'h1_0000_0000)
		apb(1, hpr_pkg::OFS_STATUS, 32'hff);
		apb(0, hpr_pkg::OFS_STATUS, 0); `CHK(rv, 32'h3)
		$display("defaults done");
	endtask : t_defaults
	task automatic t_ack;
		apb(1, hpr_pkg::OFS_CONTROL, 32'h1); wait_for(haptic_start, 1, 10); `CHK(n, 10)
		apb(1, hpr_pkg::OFS_CONTROL, 32'h4);
		apb(0, hpr_pkg::OFS_STATUS, 0); `CHK(rv[0], 1'b0)
		apb(0, hpr_pkg::OFS_CONTROL, 0); `CHK(rv[2], 1'b0)
		apb(1, hpr_pkg::OFS_CONTROL, 32'h4);
		apb(0, hpr_pkg::OFS_CONTROL, 0); `CHK(rv[2:0], 3'h0)
		$display("ack done");
	endtask : t_ack
	task automatic t_run;
		apb(1, hpr_pkg::OFS_SETTINGS, 32'h100);
		apb(1, hpr_pkg::OFS_CONTROL, 32'h1); wait_for(haptic_start, 1, 10); `CHK(n < 5, 1'b1)
		apb(0, hpr_pkg::OFS_STATUS, 0); `CHK(rv[2], 1'b1)
		apb(1, hpr_pkg::OFS_CONTROL, 32'h2);
		apb(0, hpr_pkg::OFS_STATUS, 0); `CHK(rv[0], 1'b0)
		wait_for(wave_running, 0, 40);
		apb(1, hpr_pkg::OFS_SETTINGS, 32'h102); wait_for(core_power_en, 0, 200);
		`CHK(n >= 20 && n <= 45, 1'b1)
		`CHK(motor_p_oe, 1'b0)
		apb(1, hpr_pkg::OFS_CONTROL, 32'h1); wait_for(haptic_start, 1, 40);
		`CHK(n >= 10 && n < 30, 1'b1)
		$display("run and sleep done");
	endtask : t_run
	task automatic t_pin;
		wait_for(core_power_en, 0, 300);
		trig_pin <= 1;
		wait_for(haptic_start, 1, 60); `CHK(n >= 10 && n < 60, 1'b1)
		repeat (40) @(posedge pclk);
		`CHK(power_fast, 1'b1)
		`CHK(wave_running | haptic_start, 1'b0)
		trig_pin <= 0;
		wait_for(core_power_en, 0, 200); `CHK(n >= 20, 1'b1)
		link_on = 1;
		wait_for(core_power_en, 1, 100); `CHK(n < 100, 1'b1)
		link_on = 0;
		wait_for(power_fast, 1, 40); `CHK(power_fast, 1'b1)
		$display("pin and link done");
	endtask : t_pin
	task automatic t_resets;
		apb(1, hpr_pkg::OFS_HBRIDGE, 32'he5);
		apb(1, hpr_pkg::OFS_CONTROL, 32'h2);
		apb(0, hpr_pkg::OFS_HBRIDGE, 0); `CHK(rv, 32'h65)
		apb(1, hpr_pkg::OFS_CONTROL, 32'h4);
		hard_reset_n <= 0;
		repeat (4) @(posedge pclk);
		hard_reset_n <= 1;
		repeat (3) @(posedge pclk);
		apb(0, hpr_pkg::OFS_STATUS, 0); `CHK(rv[0], 1'b1)
		apb(1, hpr_pkg::OFS_CONTROL, 32'h4);
		$display("resets done");
	endtask : t_resets
	task automatic t_bridge;
		apb(1, hpr_pkg::OFS_SETTINGS, 32'h100);
		apb(1, hpr_pkg::OFS_HBRIDGE, 32'hf5); repeat (3) @(posedge pclk);
		`CHK({motor_p_oe, motor_p_o}, 2'b10)
		apb(1, hpr_pkg::OFS_CONTROL, 32'h1); repeat (6) @(posedge pclk);
		`CHK(stage_en, 7'h1f)
		oc_sense <= 1; repeat (5) @(posedge pclk);
		`CHK(stage_en, 7'h0)
		oc_sense <= 0; wait_for(wave_running, 0, 40);
		apb(0, hpr_pkg::OFS_STATUS, 0); `CHK(rv[3], 1'b1)
		apb(0, hpr_pkg::OFS_STATUS, 0); `CHK(rv[3], 1'b0)
		apb(1, hpr_pkg::OFS_HBRIDGE, 32'h33);
		apb(1, hpr_pkg::OFS_CONTROL, 32'h1); oc_sense <= 1; repeat (6) @(posedge pclk);
		`CHK(stage_en, 7'h07)
		oc_sense <= 0; temp_code <= 8'h90; wait_for(wave_running, 0, 40);
		apb(0, hpr_pkg::OFS_STATUS, 0); `CHK(rv[4:3], 2'b10)
		temp_code <= 8'h7e;
		apb(0, hpr_pkg::OFS_STATUS, 0);
		apb(0, hpr_pkg::OFS_STATUS, 0); `CHK(rv[4], 1'b1)
		temp_code <= 8'h10;
		apb(1, hpr_pkg::OFS_HBRIDGE, 32'h105);
		apb(1, hpr_pkg::OFS_CONTROL, 32'h1); repeat (6) @(posedge pclk);
		`CHK({stage_en, motor_p_oe}, 8'h01)
		`CHK({motor_p_o, motor_n_o, motor_n_oe}, 3'b011)
		apb(1, hpr_pkg::OFS_SETTINGS, 32'h1); wait_for(core_power_en, 0, 40);
		`CHK(n < 40, 1'b1)
		$display("bridge done");
	endtask : t_bridge
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	initial
	begin
		#200000;
		mismatches++;
		report_and_stop();
	end
	initial
	begin
		presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		hard_reset_n = 1; trig_pin = 0; serial_clk = 0; oc_sense = 0; link_on = 0;
		temp_code = 8'h10; mismatches = 0; tests_run = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_defaults();
		t_ack();
		t_run();
		t_pin();
		t_resets();
		t_bridge();
		report_and_stop();
	end
endmodule : tb
